// File: mdpi_pkg.sv
// Purpose: Shared constants and types for the DRAM pin interface
// Assumes: 200 MHz core clock, one clock domain
// Notes: Times are kept in ps, cycle counts derived from them
package mdpi_pkg;
  localparam int DQ_W = 64;
  localparam int ECC_W = 8;
  localparam int ROWS = 6;
  localparam int BYTES = 8;
  localparam int ADDR_W = 14;
  localparam int SEL_W = 3;
  localparam int CNT_W = 4;
  localparam int FIFO_DEPTH = 16;
  // Timing in ps; least times round up
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_RCD_PS = 20000;
  localparam int T_RP_PS = 20000;
  localparam int RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAS_LAT = 2;
  localparam int SYNC_STAGES = 2;
  localparam int RD_CYC = CAS_LAT + SYNC_STAGES;
  // Address pins 9:0 and 12:11 are active low, 10 and 13 active high
  localparam logic [ADDR_W-1:0] ADDR_INV_MASK = 14'h1bff;
  // Bit 10 high selects all banks on SDRAM precharge
  localparam logic [ADDR_W-1:0] ADDR_PRE_ALL = 14'h0400;
  localparam logic MEM_EDO = 1'b0;
  localparam logic MEM_SDRAM = 1'b1;
  localparam logic [ROWS-1:0] CKE_RST = 6'h3f;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_COL = 3'h3,
    ST_RD = 3'h2,
    ST_PRE = 3'h6
  } mdpi_state_t;
  typedef struct packed {
    logic wr;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [BYTES-1:0] mask;
    logic [ECC_W-1:0] ecc;
    logic [DQ_W-1:0] data;
  } mdpi_req_t;
  localparam int REQ_W = $bits(mdpi_req_t);
endpackage

// File: mdpi_stream_if.sv
// Purpose: Valid/ready word stream between the block's modules
// Assumes: Producer holds data while valid and not ready
// Notes: No clocking block; both ends share core clock
`timescale 1ns/1ps
interface mdpi_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// File: mdpi_fifo.sv
// Purpose: Request FIFO in front of the DRAM sequencer
// Assumes: Depth is a power of two
// Notes: Full is registered so the fill-side ready is a flop
`timescale 1ns/1ps
module mdpi_fifo #(
  parameter int W = 8,
  parameter int D = 16
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  mdpi_stream_if.rx in_if,
  mdpi_stream_if.tx out_if
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic full_reg, full_next;
  logic push, pop;

  // Handshakes on both sides
  assign push = in_if.valid && !full_reg;
  assign pop = out_if.valid && out_if.ready;
  assign in_if.ready = !full_reg;
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data = mem[rp_reg];

  // Pointers wrap naturally at a power-of-two depth
  always_comb
  begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    full_next = (cnt_next == (AW+1)'(D));
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wp_reg] <= in_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
    end
  end
endmodule

// File: mdpi_top.sv
// Purpose: DRAM pin sequencer for EDO or SDRAM behind a request FIFO
// Assumes: Requests and config come from core-clock logic
// Notes: Data and check-bit inputs pass two sync flops
// Operation
// - Eight check bits travel with the data bus on every access.
// - EDO uses six active-low row strobes to select the row.
// - EDO uses eight active-low column strobes to select the column.
// - SDRAM reuses them as read output enables and write byte masks.
// - Row and column share one address bus with mixed pin polarity.
// - One write enable pin controls writes for both memory types.
// - SDRAM row strobe low latches the row and also drives precharge.
// - SDRAM column strobe low latches the column for the access.
// - Six clock enables; dropping one powers its SDRAM down.
// - Each row has its own clock enable, driven independently.
// - Data moves over a 64-bit two-way bus straight to the DRAM.
`timescale 1ns/1ps
module mdpi_top
  import mdpi_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic mem_type_i,
  input wire logic [ROWS-1:0] pd_req_i,
  input wire logic req_valid_i,
  input wire mdpi_req_t req_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [DQ_W-1:0] rd_data_o,
  output logic [ECC_W-1:0] rd_ecc_o,
  input wire logic [DQ_W-1:0] memory_data_bus_i,
  output logic [DQ_W-1:0] memory_data_bus_o,
  output logic memory_data_bus_oe_o,
  input wire logic [ECC_W-1:0] memory_check_bits_i,
  output logic [ECC_W-1:0] memory_check_bits_o,
  output logic memory_check_bits_oe_o,
  output logic [ROWS-1:0] edo_row_strobe_n_o,
  output logic [BYTES-1:0] edo_column_strobe_n_o,
  output logic [ADDR_W-1:0] memory_address_set_b_o,
  output logic memory_write_enable_n_o,
  output logic sdram_row_strobe_n_o,
  output logic sdram_column_strobe_n_o,
  output logic [ROWS-1:0] sdram_clock_enable_o
);
  // One-hot row select; select codes above five hit no row
  function automatic logic [ROWS-1:0] row_sel(input logic [SEL_W-1:0] s);
    row_sel = ROWS'(6'h01 << s);
  endfunction

  // Logical address to pin levels
  function automatic logic [ADDR_W-1:0] pin_addr(
    input logic [ADDR_W-1:0] a);
    pin_addr = a ^ ADDR_INV_MASK;
  endfunction

  mdpi_stream_if #(.W(REQ_W)) push_if ();
  mdpi_stream_if #(.W(REQ_W)) pop_if ();

  mdpi_fifo #(.W(REQ_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .in_if (push_if),
    .out_if (pop_if)
  );

  mdpi_state_t state_reg, state_next;
  mdpi_req_t req_reg, req_next, head;
  logic type_reg, type_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic pop, go_pre;
  logic rdv_next;
  logic [DQ_W-1:0] rdd_next, dq_next, dq_s1, dq_s2;
  logic [ECC_W-1:0] rde_next, ecc_next, ecc_s1, ecc_s2;
  logic oe_next, we_next, sras_next, scas_next;
  logic [ROWS-1:0] ras_next, cke_next;
  logic [BYTES-1:0] cas_next;
  logic [ADDR_W-1:0] addr_next;

  assign push_if.valid = req_valid_i;
  assign push_if.data = req_i;
  assign req_ready_o = push_if.ready;
  assign head = mdpi_req_t'(pop_if.data);
  assign pop_if.ready = pop;

  // Pin inputs cross in through two flops before capture
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      ecc_s1 <= '0;
      ecc_s2 <= '0;
    end
    else
    begin
      dq_s1 <= memory_data_bus_i;
      dq_s2 <= dq_s1;
      ecc_s1 <= memory_check_bits_i;
      ecc_s2 <= ecc_s1;
    end
  end

  // Sequencer and pin next values; pins idle unless a state drives them
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    req_next = req_reg;
    type_next = type_reg;
    pop = 1'b0;
    go_pre = 1'b0;
    rdv_next = 1'b0;
    rdd_next = rd_data_o;
    rde_next = rd_ecc_o;
    ras_next = '1;
    cas_next = '1;
    addr_next = memory_address_set_b_o;
    we_next = 1'b1;
    sras_next = 1'b1;
    scas_next = 1'b1;
    oe_next = 1'b0;
    dq_next = memory_data_bus_o;
    ecc_next = memory_check_bits_o;
    cke_next = ~pd_req_i;
    case (state_reg)
      ST_IDLE:
      begin
        if (pop_if.valid)
        begin
          // Type latched here holds for the whole access
          pop = 1'b1;
          req_next = head;
          type_next = mem_type_i;
          state_next = ST_ROW;
          cnt_next = CNT_W'(RCD_CYC - 1);
          addr_next = pin_addr(head.row);
          ras_next = ~row_sel(head.sel);
          sras_next = (mem_type_i != MEM_SDRAM);
        end
      end
      ST_ROW:
      begin
        // SDRAM gets NOPs here; EDO holds its row strobe low
        if (type_reg == MEM_EDO)
        begin
          ras_next = ~row_sel(req_reg.sel);
        end
        if (cnt_reg != '0)
        begin
          cnt_next = cnt_reg - 1'b1;
        end
        else
        begin
          state_next = ST_COL;
          addr_next = pin_addr(req_reg.col);
          ras_next = ~row_sel(req_reg.sel);
          we_next = ~req_reg.wr;
          oe_next = req_reg.wr;
          dq_next = req_reg.data;
          ecc_next = req_reg.ecc;
          // Same pins: EDO column strobes or SDRAM byte masks
          cas_next = req_reg.wr ? req_reg.mask : '0;
          scas_next = (type_reg != MEM_SDRAM);
        end
      end
      ST_COL:
      begin
        if (req_reg.wr)
        begin
          go_pre = 1'b1;
        end
        else
        begin
          state_next = ST_RD;
          cnt_next = CNT_W'(RD_CYC - 1);
          cas_next = '0;
          if (type_reg == MEM_EDO)
          begin
            ras_next = ~row_sel(req_reg.sel);
          end
        end
      end
      ST_RD:
      begin
        // Read enables stay low until the sampled data is taken
        cas_next = '0;
        if (type_reg == MEM_EDO)
        begin
          ras_next = ~row_sel(req_reg.sel);
        end
        if (cnt_reg != '0)
        begin
          cnt_next = cnt_reg - 1'b1;
        end
        else
        begin
          rdv_next = 1'b1;
          rdd_next = dq_s2;
          rde_next = ecc_s2;
          go_pre = 1'b1;
        end
      end
      ST_PRE:
      begin
        if (cnt_reg != '0)
        begin
          cnt_next = cnt_reg - 1'b1;
        end
        else
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    // Close the row; EDO just releases strobes for the precharge time
    if (go_pre)
    begin
      state_next = ST_PRE;
      cnt_next = CNT_W'(RP_CYC - 1);
      cas_next = '1;
      if (type_reg == MEM_SDRAM)
      begin
        ras_next = ~row_sel(req_reg.sel);
        sras_next = 1'b0;
        we_next = 1'b0;
        addr_next = pin_addr(ADDR_PRE_ALL);
      end
    end
  end

  // Every pin and status output is a flop
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      req_reg <= '0;
      type_reg <= MEM_EDO;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      rd_ecc_o <= '0;
      edo_row_strobe_n_o <= '1;
      edo_column_strobe_n_o <= '1;
      memory_address_set_b_o <= ADDR_INV_MASK;
      memory_write_enable_n_o <= 1'b1;
      sdram_row_strobe_n_o <= 1'b1;
      sdram_column_strobe_n_o <= 1'b1;
      memory_data_bus_oe_o <= 1'b0;
      memory_check_bits_oe_o <= 1'b0;
      memory_data_bus_o <= '0;
      memory_check_bits_o <= '0;
      sdram_clock_enable_o <= CKE_RST;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      type_reg <= type_next;
      rd_valid_o <= rdv_next;
      rd_data_o <= rdd_next;
      rd_ecc_o <= rde_next;
      edo_row_strobe_n_o <= ras_next;
      edo_column_strobe_n_o <= cas_next;
      memory_address_set_b_o <= addr_next;
      memory_write_enable_n_o <= we_next;
      sdram_row_strobe_n_o <= sras_next;
      sdram_column_strobe_n_o <= scas_next;
      memory_data_bus_oe_o <= oe_next;
      memory_check_bits_oe_o <= oe_next;
      memory_data_bus_o <= dq_next;
      memory_check_bits_o <= ecc_next;
      sdram_clock_enable_o <= cke_next;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Check bits drive only in a write's column cycle, with that word's code
  property p_ecc_with_data;
    memory_check_bits_oe_o == memory_data_bus_oe_o
      && (!memory_data_bus_oe_o || (state_reg == ST_COL && req_reg.wr
      && memory_check_bits_o == req_reg.ecc));
  endproperty
  a_ecc_with_data: assert property (p_ecc_with_data)
    else $error("check bits not driven with data");

  property p_edo_row;
    (state_reg == ST_ROW && type_reg == MEM_EDO)
      |-> edo_row_strobe_n_o == ~row_sel(req_reg.sel);
  endproperty
  a_edo_row: assert property (p_edo_row)
    else $error("EDO row strobe wrong during row phase");

  property p_col_mask;
    (state_reg == ST_COL)
      |-> edo_column_strobe_n_o == (req_reg.wr ? req_reg.mask : '0);
  endproperty
  a_col_mask: assert property (p_col_mask)
    else $error("column strobe or byte mask wrong");

  property p_row_addr;
    $rose(state_reg == ST_ROW)
      |-> memory_address_set_b_o == (req_reg.row ^ ADDR_INV_MASK);
  endproperty
  a_row_addr: assert property (p_row_addr)
    else $error("row address pins wrong");

  property p_we_place;
    !memory_write_enable_n_o |-> state_reg inside {ST_COL, ST_PRE};
  endproperty
  a_we_place: assert property (p_we_place)
    else $error("write enable outside column or precharge");

  property p_sdram_act;
    ($rose(state_reg == ST_ROW) && type_reg == MEM_SDRAM)
      |-> !sdram_row_strobe_n_o ##1 sdram_row_strobe_n_o;
  endproperty
  a_sdram_act: assert property (p_sdram_act)
    else $error("SDRAM activate not a single low cycle");

  property p_sdram_col;
    (state_reg == ST_COL && type_reg == MEM_SDRAM)
      |-> !sdram_column_strobe_n_o && edo_row_strobe_n_o != '1
          ##1 sdram_column_strobe_n_o;
  endproperty
  a_sdram_col: assert property (p_sdram_col)
    else $error("SDRAM column command malformed");

  property p_cke;
    ##1 sdram_clock_enable_o == ~$past(pd_req_i);
  endproperty
  a_cke: assert property (p_cke)
    else $error("clock enable not following power-down request");

  property p_read_done;
    (state_reg == ST_COL && !req_reg.wr) |-> ##[1:8] rd_valid_o;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("read data not returned in time");

  property p_type_stable;
    (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE)
      |-> $stable(type_reg);
  endproperty
  a_type_stable: assert property (p_type_stable)
    else $error("memory type changed inside an access");

  c_sdram_write: cover property (state_reg == ST_COL
    && type_reg == MEM_SDRAM && req_reg.wr);
  c_edo_read: cover property (rd_valid_o && type_reg == MEM_EDO);
  c_fifo_full: cover property (!req_ready_o);
endmodule

// File: mdpi_mem_model.sv
// Purpose: Behavioural EDO/SDRAM devices on the far side of the pins
// Assumes: Address pins decoded with the package polarity mask
// Notes: Released data lines toggle so stale values never pass
`timescale 1ns/1ps
module mdpi_mem_model
  import mdpi_pkg::*;
(
  input wire logic clk_i,
  input wire logic mem_type_i,
  input wire logic [ROWS-1:0] sel_n_i,
  input wire logic [BYTES-1:0] col_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic we_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic [ROWS-1:0] cke_i,
  input wire logic [DQ_W-1:0] dq_i,
  input wire logic [ECC_W-1:0] ecc_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [ECC_W-1:0] ecc_o
);
  logic [DQ_W+ECC_W-1:0] mem [logic [30:0]];
  logic [ADDR_W-1:0] row_q [ROWS];
  logic [ROWS-1:0] sel_q = '1;
  logic [BYTES-1:0] col_q = '1;
  logic [DQ_W+ECC_W-1:0] rd_word = '0;
  logic [30:0] key;
  logic [ADDR_W-1:0] a;
  logic act;
  logic col;
  int hold = 0;
  int s;
  initial dq_o = '0;
  initial ecc_o = '0;
  // Decode commands each edge; data follows two edges after a read
  always @(posedge clk_i)
  begin
    a = addr_i ^ ADDR_INV_MASK;
    s = 0;
    for (int i = ROWS - 1; i >= 0; i--)
      if (!sel_n_i[i])
        s = i;
    if (mem_type_i == MEM_SDRAM)
    begin
      // Powered-down or unselected devices ignore commands
      col = (sel_n_i != '1) && cke_i[s];
      act = col && !ras_n_i && cas_n_i && we_n_i;
      col = col && ras_n_i && !cas_n_i;
    end
    else
    begin
      act = sel_q[s] && !sel_n_i[s];
      col = (sel_n_i != '1) && (col_q == '1) && (col_n_i != '1);
    end
    if (hold > 0)
      hold--;
    if (act)
      row_q[s] = a;
    if (col)
    begin
      key = {s[2:0], row_q[s], a};
      if (!mem.exists(key))
        mem[key] = '0;
      if (!we_n_i)
      begin
        // Low strobe or mask bit lets that byte through
        for (int b = 0; b < BYTES; b++)
          if (!col_n_i[b])
            mem[key][b*8 +: 8] = dq_i[b*8 +: 8];
        mem[key][DQ_W +: ECC_W] = ecc_i;
      end
      else
      begin
        rd_word = mem[key];
        hold = 6;
      end
    end
    sel_q = sel_n_i;
    col_q = col_n_i;
    dq_o <= (hold > 0 && hold < 6) ? rd_word[DQ_W-1:0] : ~dq_o;
    ecc_o <= (hold > 0 && hold < 6) ? rd_word[DQ_W +: ECC_W] : ~ecc_o;
  end
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the DRAM pin sequencer
// Assumes: Mode changes only while the sequencer is idle
// Notes: Reference memory in queues and maps, compared per read
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((ex) !== (got)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  import mdpi_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mem_type_i = MEM_EDO;
  logic [ROWS-1:0] pd_req_i = '0;
  logic req_valid_i = 1'b0;
  mdpi_req_t req_i = '0;
  logic req_ready_o, rd_valid_o, dq_oe, ecc_oe, we_n, ras_n, cas_n;
  logic [DQ_W-1:0] rd_data_o, dut_dq, mdl_dq, dq_w;
  logic [ECC_W-1:0] rd_ecc_o, dut_ecc, mdl_ecc, ecc_w;
  logic [ROWS-1:0] sel_n, cke;
  logic [BYTES-1:0] col_n;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W+ECC_W-1:0] ref_mem [logic [30:0]];
  logic [DQ_W+ECC_W-1:0] exp_q [$];
  logic [DQ_W+ECC_W-1:0] exp_word;
  logic [SEL_W-1:0] ksel [10];
  logic [ADDR_W-1:0] krow [10];
  logic [ADDR_W-1:0] kcol [10];
  int num_errors = 0;
  int compares = 0;
  int refusals = 0;
  int seed = 32'h5f0fab6a;
  always #2.5 core_clk_i = ~core_clk_i;
  // Wire level: the DUT wins when it enables, otherwise the model's read data or toggling
  assign dq_w = dq_oe ? dut_dq : mdl_dq;
  assign ecc_w = ecc_oe ? dut_ecc : mdl_ecc;
  mdpi_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mem_type_i(mem_type_i), .pd_req_i(pd_req_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ecc_o(rd_ecc_o),
    .memory_data_bus_i(dq_w), .memory_data_bus_o(dut_dq),
    .memory_data_bus_oe_o(dq_oe), .memory_check_bits_i(ecc_w),
    .memory_check_bits_o(dut_ecc), .memory_check_bits_oe_o(ecc_oe),
    .edo_row_strobe_n_o(sel_n), .edo_column_strobe_n_o(col_n),
    .memory_address_set_b_o(addr), .memory_write_enable_n_o(we_n),
    .sdram_row_strobe_n_o(ras_n), .sdram_column_strobe_n_o(cas_n),
    .sdram_clock_enable_o(cke));
  mdpi_mem_model u_mem (.clk_i(core_clk_i), .mem_type_i(mem_type_i),
    .sel_n_i(sel_n), .col_n_i(col_n), .addr_i(addr), .we_n_i(we_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .cke_i(cke), .dq_i(dq_w),
    .ecc_i(ecc_w), .dq_o(mdl_dq), .ecc_o(mdl_ecc));
  // Results and pin commands checked where outputs have settled
  always @(negedge core_clk_i)
  begin
    if (rst_n_i && rd_valid_o === 1'b1)
    begin
      // Pop once; the compare macro names its expected value twice
      exp_word = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
      `CHK("read_word", exp_word, {rd_ecc_o, rd_data_o})
    end
    if (rst_n_i && mem_type_i == MEM_SDRAM && sel_n != '1 && !ras_n &&
        cas_n && !we_n)
      `CHK("precharge_addr", ADDR_PRE_ALL, addr ^ ADDR_INV_MASK)
    if (rst_n_i && mem_type_i == MEM_EDO)
      `CHK("edo_sdram_strobes", 2'b11, {ras_n, cas_n})
  end
  task automatic conclude();
    $display("Checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One request; valid stays high so back-to-back pushes never glitch
  task automatic send(input logic wr, input int k, input logic [7:0] m);
    logic [30:0] key;
    int b;
    key = {ksel[k], krow[k], kcol[k]};
    req_i = {wr, ksel[k], krow[k], kcol[k], m, 8'($random(seed)),
      $random(seed), $random(seed)};
    if (!ref_mem.exists(key))
      ref_mem[key] = '0;
    if (wr)
    begin
      for (b = 0; b < BYTES; b++)
        if (!m[b])
          ref_mem[key][b*8 +: 8] = req_i.data[b*8 +: 8];
      // EDO with every byte masked raises no column strobe: nothing lands
      if (mem_type_i == MEM_SDRAM || m != 8'hff)
        ref_mem[key][DQ_W +: ECC_W] = req_i.ecc;
    end
    else
      exp_q.push_back(ref_mem[key]);
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1)
    begin
      refusals++;
      @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (2) @(negedge core_clk_i);
    `CHK("reset_strobes", {6'h3f, 8'hff}, {sel_n, col_n})
    `CHK("reset_addr", {ADDR_INV_MASK, CKE_RST}, {addr, cke})
    `CHK("reset_idle", 4'hf, {ras_n, cas_n, we_n, !dq_oe})
    rst_n_i = 1'b1;
    // Each row's clock enable follows its own power-down request
    repeat (3)
    begin
      pd_req_i = 6'($random(seed));
      repeat (2) @(negedge core_clk_i);
      `CHK("clock_enable", ~pd_req_i, cke)
    end
    pd_req_i = '0;
    for (int md = 0; md < 2; md++)
    begin
      mem_type_i = md[0];
      for (int k = 0; k < 10; k++)
      begin
        ksel[k] = 3'($unsigned($random(seed)) % ROWS);
        krow[k] = 14'($random(seed));
        kcol[k] = 14'($random(seed));
      end
      // Rewrites with random masks exercise byte merging
      for (int i = 0; i < 20; i++)
        send(1'b1, i % 10, (i < 10) ? 8'h00 : 8'($random(seed)));
      for (int i = 0; i < 20; i++)
        send(1'b0, i % 10, 8'h00);
      req_valid_i = 1'b0;
      for (int t = 0; t < 1000 && exp_q.size() != 0; t++)
        @(negedge core_clk_i);
      repeat (20) @(negedge core_clk_i);
    end
    `CHK("reads_left", 0, exp_q.size())
    `CHK("fifo_refused", 1'b1, refusals > 0)
    conclude();
  end
endmodule
